// ### core/dual_timer_event_counter.v
// Functional notes
// RULE_01: Counter0 is 8-bit up, three clock sources
// RULE_02: Counter1 is 16-bit up, three clock sources
// RULE_03: Control bits 0-2 pick divide 2..256
// RULE_04: Counter0 bit 3 selects active edge
// RULE_05: Counter1 edge bit 3, bits 0-2,5 zero
// RULE_06: Bit 4 runs counting, bit 5 zero
// RULE_07: Bits 7:6 pick event, timer, pulse mode
// RULE_08: Event mode uses pin, others internal clock
// RULE_09: Slow crystal source only with RC+RTC oscillator
// RULE_10: Counter0 write preloads, read returns live count
// RULE_11: Low write buffers, high write loads preload
// RULE_12: High read latches low into buffer
// RULE_13: Overflow reloads preload and sets flag
// RULE_14: Pulse mode counts between edge and return
// RULE_15: One measurement per run bit setting
// RULE_16: Pulse mode triggers on transitions only
// RULE_17: Pulse mode overflow reloads and flags too
// RULE_18: Hardware clears run only after pulse measurement
// RULE_19: Any overflow wakes the halted device
// RULE_20: Enable bit zero blocks overflow interrupt
// RULE_21: Stopped counter also loads on preload write
// RULE_22: Counting clock blocked during counter read
// RULE_23: Counter0 overflow drives divided buzzer output
// RULE_24: Buzzer output toggles on every overflow0
//
// The address-and-strobe port is this design's own decision.
`include "dual_timer_regs.vh"

module dual_timer_event_counter
(
  input  wire       ref_clk,      // System clock
  input  wire       rst,          // Synchronous reset, active high
  input  wire [7:0] addr,         // Register address
  input  wire [7:0] wrData,       // Write data
  input  wire       wrEn,         // Write strobe
  input  wire       rdEn,         // Read strobe
  output reg  [7:0] rdData,       // Read data, cycle after strobe
  input  wire       eventPin0,    // Counter0 external input
  input  wire       eventPin1,    // Counter1 external input
  input  wire       rtcTick,      // Slow crystal clock, sampled level
  input  wire       rtcAllowed,   // Oscillator set to RC plus RTC
  input  wire       useRtc0,      // Counter0 internal source option
  input  wire       useRtc1,      // Counter1 internal source option
  output wire       irqRequest,   // Enabled overflow pending
  output reg        wakeUp,       // One-cycle pulse on any overflow
  output reg        toggleOut     // Overflow-divided square wave
);

  // Counter state
  reg  [7:0]  count0;             // Live counter0
  reg  [7:0]  preload0;           // Counter0 preload
  reg  [7:0]  ctl0;               // Counter0 control
  reg  [15:0] count1;             // Live counter1
  reg  [15:0] preload1;           // Counter1 preload
  reg  [7:0]  lowBuf;             // Counter1 low byte buffer
  reg  [7:0]  ctl1;               // Counter1 control
  reg  [7:0]  intCtl;             // Interrupt control
  reg  [7:0]  prescale;           // Free prescaler for counter0
  reg  [1:0]  div4;               // Quarter divider for counter1
  reg         pinPrev0;           // Last pin0 level
  reg         pinPrev1;           // Last pin1 level
  reg         rtcPrev;            // Last slow clock level
  reg         measuring0;         // Pulse measurement active
  reg         measuring1;
  reg         armed0;             // Waiting for starting edge
  reg         armed1;
  reg  [7:0]  prescalePrev;       // Prescaler value last cycle

  // Source selection; slow clock only legal in RC+RTC oscillator
  wire rtcRise  = rtcTick & ~rtcPrev;
  wire sel0Rtc  = useRtc0 & rtcAllowed;            // see RULE_09
  wire sel1Rtc  = useRtc1 & rtcAllowed;            // see RULE_09

  // Counter0 base ticks and prescaler tap
  wire [7:0] stageRise = prescale & ~prescalePrev;
  wire       rtcDivTick;
  reg  [7:0] rtcDiv;              // Prescaler on the slow clock
  wire [2:0] psc0 = ctl0[`CTL_PSC_MSB:`CTL_PSC_LSB];
  // Bit k of a free counter rises once every 2^(k+1) ticks
  wire       sysDivTick = stageRise[psc0];          // see RULE_03
  reg  [7:0] rtcDivPrev;
  wire [7:0] rtcStage = rtcDiv & ~rtcDivPrev;
  assign     rtcDivTick = rtcStage[psc0];           // see RULE_03
  wire int0Tick = sel0Rtc ? rtcDivTick : sysDivTick; // see RULE_01
  wire int1Tick = sel1Rtc ? rtcRise : (div4 == `DIV4_LAST); // see RULE_02

  // Edge detection on external pins, polarity from control bit 3
  wire rise0 = eventPin0 & ~pinPrev0;
  wire fall0 = ~eventPin0 & pinPrev0;
  wire rise1 = eventPin1 & ~pinPrev1;
  wire fall1 = ~eventPin1 & pinPrev1;
  wire act0  = ctl0[`CTL_EDGE] ? fall0 : rise0;     // see RULE_04
  wire ret0  = ctl0[`CTL_EDGE] ? rise0 : fall0;
  wire act1  = ctl1[`CTL_EDGE] ? fall1 : rise1;     // see RULE_05
  wire ret1  = ctl1[`CTL_EDGE] ? rise1 : fall1;

  wire [1:0] mode0 = ctl0[`CTL_MODE_MSB:`CTL_MODE_LSB];
  wire [1:0] mode1 = ctl1[`CTL_MODE_MSB:`CTL_MODE_LSB];
  wire run0 = ctl0[`CTL_RUN];
  wire run1 = ctl1[`CTL_RUN];

  // Reads of live counts freeze counting for that cycle
  wire rdCnt0 = rdEn & (addr == `ADDR_CNT0);        // see RULE_22
  wire rdCnt1 = rdEn & ((addr == `ADDR_CNT1_HI) | (addr == `ADDR_CNT1_LO)); // see RULE_22

  // Pulse measurement ends when input returns to start level
  wire end0 = (mode0 == `MODE_PULSE) & measuring0 & ret0; // see RULE_14
  wire end1 = (mode1 == `MODE_PULSE) & measuring1 & ret1; // see RULE_14

  // Count enables per mode; mode 00 never counts
  reg cnt0Step;
  reg cnt1Step;
  always @*
  begin
    cnt0Step = 1'b0;
    cnt1Step = 1'b0;
    case (mode0)
      `MODE_EVENT: cnt0Step = run0 & act0;                      // see RULE_08
      `MODE_TIMER: cnt0Step = run0 & int0Tick;                  // see RULE_08
      `MODE_PULSE: cnt0Step = run0 & measuring0 & ~end0 & int0Tick;
      default:     cnt0Step = 1'b0;
    endcase
    case (mode1)
      `MODE_EVENT: cnt1Step = run1 & act1;                      // see RULE_08
      `MODE_TIMER: cnt1Step = run1 & int1Tick;                  // see RULE_08
      `MODE_PULSE: cnt1Step = run1 & measuring1 & ~end1 & int1Tick;
      default:     cnt1Step = 1'b0;
    endcase
  end
  wire step0 = cnt0Step & ~rdCnt0;
  wire step1 = cnt1Step & ~rdCnt1;
  wire ovf0  = step0 & (count0 == `ONES8);           // see RULE_13
  wire ovf1  = step1 & (count1 == `ONES16);          // see RULE_13

  wire wrCnt0 = wrEn & (addr == `ADDR_CNT0);
  wire wrHi   = wrEn & (addr == `ADDR_CNT1_HI);
  wire wrLo   = wrEn & (addr == `ADDR_CNT1_LO);
  wire wrCtl0 = wrEn & (addr == `ADDR_CNT0_CTL);
  wire wrCtl1 = wrEn & (addr == `ADDR_CNT1_CTL);
  wire wrInt  = wrEn & (addr == `ADDR_INT_CTL);

  // Interrupt request gated by enable bits
  assign irqRequest = (intCtl[`INT_FLAG0] & intCtl[`INT_EN0]) |
                      (intCtl[`INT_FLAG1] & intCtl[`INT_EN1]); // see RULE_20

  // Dividers and edge history
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      prescale     <= `ZERO8;
      prescalePrev <= `ZERO8;
      rtcDiv       <= `ZERO8;
      rtcDivPrev   <= `ZERO8;
      div4         <= 2'h0;
      pinPrev0     <= 1'b0;
      pinPrev1     <= 1'b0;
      rtcPrev      <= 1'b0;
    end
    else
    begin
      prescale     <= prescale + `ONE8;
      prescalePrev <= prescale;
      rtcDivPrev   <= rtcDiv;
      // Slow prescaler advances only on slow clock edges
      if (rtcRise)
        rtcDiv <= rtcDiv + `ONE8;
      div4         <= div4 + 2'h1;
      pinPrev0     <= eventPin0;
      pinPrev1     <= eventPin1;
      rtcPrev      <= rtcTick;
    end
  end

  // Counter0 datapath and control
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      count0     <= `ZERO8;
      preload0   <= `ZERO8;
      ctl0       <= `CTL0_RESET;
      measuring0 <= 1'b0;
      armed0     <= 1'b0;
      toggleOut  <= 1'b0;
    end
    else
    begin
      // Preload write; also loads counter when stopped
      if (wrCnt0)
        preload0 <= wrData;                                   // see RULE_10
      if (wrCnt0 & ~run0)
        count0 <= wrData;                                     // see RULE_21
      else if (ovf0)
        count0 <= preload0;                                   // see RULE_13, RULE_17
      else if (step0)
        count0 <= count0 + `ONE8;                             // see RULE_01
      if (ovf0)
        toggleOut <= ~toggleOut;                              // see RULE_23, RULE_24
      // Pulse sequencing: arm on run, start on edge, stop on return
      if (wrCtl0)
      begin
        ctl0       <= wrData & `CTL0_MASK;                    // see RULE_06, RULE_07
        armed0     <= wrData[`CTL_RUN];                       // see RULE_15
        measuring0 <= 1'b0;
      end
      else if (end0)
      begin
        ctl0[`CTL_RUN] <= 1'b0;                               // see RULE_18
        measuring0     <= 1'b0;
      end
      else if (mode0 == `MODE_PULSE & run0 & armed0 & act0)
      begin
        measuring0 <= 1'b1;                                   // see RULE_16
        armed0     <= 1'b0;
      end
    end
  end

  // Counter1 datapath and control
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      count1     <= 16'h0000;
      preload1   <= 16'h0000;
      lowBuf     <= `ZERO8;
      ctl1       <= `CTL1_RESET;
      measuring1 <= 1'b0;
      armed1     <= 1'b0;
    end
    else
    begin
      // Low write fills buffer only; high read latches live low
      if (wrLo)
        lowBuf <= wrData;                                     // see RULE_11
      else if (rdEn & (addr == `ADDR_CNT1_HI))
        lowBuf <= count1[7:0];                                // see RULE_12
      if (wrHi)
        preload1 <= {wrData, lowBuf};                         // see RULE_11
      if (wrHi & ~run1)
        count1 <= {wrData, lowBuf};                           // see RULE_21
      else if (ovf1)
        count1 <= preload1;                                   // see RULE_13, RULE_17
      else if (step1)
        count1 <= count1 + `ONE16;                            // see RULE_02
      if (wrCtl1)
      begin
        ctl1       <= wrData & `CTL1_MASK;                    // see RULE_05, RULE_06
        armed1     <= wrData[`CTL_RUN];                       // see RULE_15
        measuring1 <= 1'b0;
      end
      else if (end1)
      begin
        ctl1[`CTL_RUN] <= 1'b0;                               // see RULE_18
        measuring1     <= 1'b0;
      end
      else if (mode1 == `MODE_PULSE & run1 & armed1 & act1)
      begin
        measuring1 <= 1'b1;                                   // see RULE_14, RULE_16
        armed1     <= 1'b0;
      end
    end
  end

  // Interrupt control: hardware set wins over a software clear
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      intCtl <= `INT_RESET;
      wakeUp <= 1'b0;
    end
    else
    begin
      if (wrInt)
        intCtl <= wrData & `INT_MASK;
      if (ovf0)
        intCtl[`INT_FLAG0] <= 1'b1;                           // see RULE_13
      if (ovf1)
        intCtl[`INT_FLAG1] <= 1'b1;                           // see RULE_13
      wakeUp <= ovf0 | ovf1;                                  // see RULE_19
    end
  end

  // Read mux; unmapped addresses read zero
  always @(posedge ref_clk)
  begin
    if (rst)
      rdData <= `ZERO8;
    else if (rdEn)
    begin
      case (addr)
        `ADDR_CNT0:     rdData <= count0;                     // see RULE_10
        `ADDR_CNT0_CTL: rdData <= ctl0;
        `ADDR_CNT1_HI:  rdData <= count1[15:8];               // see RULE_12
        `ADDR_CNT1_LO:  rdData <= lowBuf;                     // see RULE_12
        `ADDR_CNT1_CTL: rdData <= ctl1;
        `ADDR_INT_CTL:  rdData <= intCtl;
        default:        rdData <= `ZERO8;
      endcase
    end
    else
      rdData <= `ZERO8;
  end

endmodule // dual_timer_event_counter

// ### inc/dual_timer_regs.vh
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH
// Register addresses
`define ADDR_CNT0      8'h0d
`define ADDR_CNT0_CTL  8'h0e
`define ADDR_CNT1_HI   8'h0f
`define ADDR_CNT1_LO   8'h10
`define ADDR_CNT1_CTL  8'h11
`define ADDR_INT_CTL   8'h0b
// Control register fields
`define CTL_PSC_LSB    0
`define CTL_PSC_MSB    2
`define CTL_EDGE       3
`define CTL_RUN        4
`define CTL_MODE_LSB   6
`define CTL_MODE_MSB   7
// Interrupt control fields
`define INT_EN0        2
`define INT_EN1        3
`define INT_FLAG0      5
`define INT_FLAG1      6
// Mode codes
`define MODE_EVENT     2'h1
`define MODE_TIMER     2'h2
`define MODE_PULSE     2'h3
// Reset values
`define CTL0_RESET     8'h08
`define CTL1_RESET     8'h08
`define INT_RESET      8'h00
`define ZERO8          8'h00
`define ONES8          8'hff
`define ONES16         16'hffff
`define ONE8           8'h01
`define ONE16          16'h0001
// Masks of implemented control bits
`define CTL0_MASK      8'hdf
`define CTL1_MASK      8'hd8
`define INT_MASK       8'h6c
// Divider for the second counter internal clock
`define DIV4_LAST      2'h3
`endif

// ### testbench/dual_timer_chk.sv
module dual_timer_chk
(
  input wire       ref_clk,
  input wire       rst,
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire       wrEn,
  input wire       rdEn,
  input wire [7:0] rdData,
  input wire       eventPin0,
  input wire       eventPin1,
  input wire       rtcTick,
  input wire       rtcAllowed,
  input wire       useRtc0,
  input wire       useRtc1,
  input wire       irqRequest,
  input wire       wakeUp,
  input wire       toggleOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic intWr;  // Software touched the interrupt control last cycle
  // A software write may raise the request without any overflow
  always_ff @(posedge ref_clk)
    intWr <= wrEn && addr == 8'h0b;
  a_rd_one_slot: assert property (rdData != 8'h00 |-> $past(rdEn))
    else $error("read data outside its slot");
  a_unmapped_zero: assert property (rdEn && !(addr inside {8'h0b, [8'h0d:8'h11]}) |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  a_ctl0_spare: assert property (rdEn && addr == 8'h0e |=> !rdData[5])
    else $error("counter0 control bit 5 set");
  a_ctl1_spare: assert property (rdEn && addr == 8'h11 |=> (rdData[5:0] & 6'h27) == 6'h00)
    else $error("counter1 control unused bits set");
  a_irq_masked: assert property (wrEn && addr == 8'h0b && wrData[3:2] == 2'h0 |=> !irqRequest)
    else $error("request with enables cleared");
  a_wake_follows: assert property ($changed(toggleOut) |-> ##[0:1] wakeUp)
    else $error("overflow without wake pulse");
  a_toggle_space: assert property ($changed(toggleOut) |=> $stable(toggleOut))
    else $error("divided output toggled twice in a row");
  a_irq_cause: assert property ($rose(irqRequest) && !intWr |-> ##[0:1] wakeUp)
    else $error("request raised without overflow");
  c_read: cover property (rdEn ##1 rdData != 8'h00);
  c_toggle: cover property ($changed(toggleOut));
  c_irq: cover property ($rose(irqRequest));
endmodule // dual_timer_chk

// ### testbench/event_source.sv
module event_source
(
  input  wire  ref_clk,
  output logic pin0,
  output logic pin1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both pins idle low; each change lands just after a clock edge
  initial {pin0, pin1} = 2'b00;
  task automatic set(input int ch, input logic v);
    @(posedge ref_clk);
    if (ch == 0)
      pin0 <= v;
    else
      pin1 <= v;
  endtask
  // Whole pulse; each level is held long enough to be seen as an edge
  task automatic pulse(input int ch, hi, lo);
    set(ch, 1'b1);
    repeat (hi) @(posedge ref_clk);
    set(ch, 1'b0);
    repeat (lo) @(posedge ref_clk);
  endtask
endmodule // event_source

// ### testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, rst, wrEn, rdEn, rtcTick, rtcAllowed, useRtc0, useRtc1;
  logic [7:0] addr, wrData, rdData, v;
  logic       eventPin0, eventPin1, irqRequest, wakeUp, toggleOut;
  int         n_mismatch, num_checks;
  dual_timer_event_counter dut (.ref_clk, .rst, .addr, .wrData, .wrEn, .rdEn, .rdData, .eventPin0, .eventPin1,
    .rtcTick, .rtcAllowed, .useRtc0, .useRtc1, .irqRequest, .wakeUp, .toggleOut);
  event_source src (.ref_clk, .pin0(eventPin0), .pin1(eventPin1));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Timed counts carry a prescaler phase of one tick either way
  task automatic in_rng(input logic [7:0] got, lo, hi);
    num_checks++;
    if ($isunknown(got) || !(got >= lo && got <= hi))
    begin
      n_mismatch++;
      $display("ERROR %0t got %h outside %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge ref_clk);
    wrEn   <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1 d = rdData;
  endtask
  task automatic rchk(input logic [7:0] a, exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // Reset values, spare bits and an unmapped place
  task automatic t_regs();
    rchk(8'h0e, 8'h08);
    rchk(8'h11, 8'h08);
    rchk(8'h0b, 8'h00);
    rchk(8'h20, 8'h00);
    wr(8'h0e, 8'hff);
    rchk(8'h0e, 8'hdf);
    wr(8'h11, 8'hff);
    rchk(8'h11, 8'hd8);
    wr(8'h0e, 8'h00);
    wr(8'h11, 8'h00);
  endtask
  // Event counting on counter0, both edges, reload and running preload
  task automatic t_event0();
    wr(8'h0d, 8'hfd);
    rchk(8'h0d, 8'hfd);
    wr(8'h0e, 8'h50);
    repeat (3) src.pulse(0, 3, 3);
    rchk(8'h0d, 8'hfd);
    rchk(8'h0b, 8'h20);
    chk({7'h0, toggleOut}, 8'h01);
    wr(8'h0e, 8'h58);
    wr(8'h0d, 8'h10);
    src.pulse(0, 3, 3);
    rchk(8'h0d, 8'hfe);
    repeat (2) src.pulse(0, 3, 3);
    rchk(8'h0d, 8'h10);
    chk({7'h0, toggleOut}, 8'h00);
  endtask
  // A read of the live count swallows an event in the same cycle
  task automatic t_block();
    wr(8'h0e, 8'h00);
    wr(8'h0d, 8'h00);
    wr(8'h0e, 8'h50);
    fork
      src.set(0, 1'b1);
      rd(8'h0d, v);
    join
    rchk(8'h0d, 8'h00);
    src.set(0, 1'b0);
    repeat (2) @(posedge ref_clk);
    src.pulse(0, 3, 3);
    rchk(8'h0d, 8'h01);
  endtask
  // Every prescaler code; slow clock asked for but not allowed
  task automatic t_prescale();
    useRtc0 <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h0e, 8'h00);
      wr(8'h0d, 8'h00);
      wr(8'h0e, {5'b10010, k[2:0]});
      repeat ((2 << k) * 4) @(posedge ref_clk);
      rd(8'h0d, v);
      in_rng(v, 8'h03, 8'h05);
    end
    wr(8'h0e, 8'h00);
  endtask
  // Byte buffering of counter1, timing at ref_clk/4, overflow and masking
  task automatic t_cnt1();
    useRtc1 <= 1'b1;
    wr(8'h10, 8'h34);
    wr(8'h0f, 8'h12);
    rchk(8'h0f, 8'h12);
    rchk(8'h10, 8'h34);
    wr(8'h11, 8'h90);
    repeat (40) @(posedge ref_clk);
    wr(8'h11, 8'h80);
    rchk(8'h0f, 8'h12);
    rd(8'h10, v);
    in_rng(v, 8'h3c, 8'h40);
    wr(8'h0b, 8'h00);
    wr(8'h10, 8'hfe);
    wr(8'h0f, 8'hff);
    wr(8'h0b, 8'h08);
    wr(8'h11, 8'h50);
    repeat (2) src.pulse(1, 3, 3);
    chk({7'h0, irqRequest}, 8'h01);
    rchk(8'h0b, 8'h48);
    rchk(8'h0f, 8'hff);
    rchk(8'h10, 8'hfe);
    wr(8'h0b, 8'h40);
    #1;
    chk({7'h0, irqRequest}, 8'h00);
  endtask
  // Slow clock drives counter1 once the oscillator allows it
  task automatic t_rtc1();
    wr(8'h11, 8'h00);
    rtcAllowed <= 1'b1;
    wr(8'h10, 8'h00);
    wr(8'h0f, 8'h00);
    wr(8'h11, 8'h90);
    repeat (5)
    begin
      @(posedge ref_clk);
      rtcTick <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rtcTick <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    wr(8'h11, 8'h80);
    rtcAllowed <= 1'b0;
    rchk(8'h0f, 8'h00);
    rchk(8'h10, 8'h05);
  endtask
  // One pulse-width measurement; a level at arming is not a start
  task automatic t_pulse0();
    src.set(0, 1'b1);
    wr(8'h0d, 8'h00);
    wr(8'h0e, 8'hd0);
    repeat (20) @(posedge ref_clk);
    rchk(8'h0d, 8'h00);
    src.set(0, 1'b0);
    repeat (4) @(posedge ref_clk);
    src.pulse(0, 40, 6);
    rd(8'h0d, v);
    in_rng(v, 8'h12, 8'h16);
    rchk(8'h0e, 8'hc0);
    src.pulse(0, 10, 6);
    rchk(8'h0d, v);
  endtask
  // A hang ends the run as a failure
  initial
  begin
    #300us;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    {rst, wrEn, rdEn, rtcTick, rtcAllowed, useRtc0, useRtc1} = 7'h40;
    {addr, wrData} = 16'h0000;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_event0();
    t_block();
    t_prescale();
    t_cnt1();
    t_rtc1();
    t_pulse0();
    stop_test();
  end
endmodule // testbench
bind dual_timer_event_counter dual_timer_chk chk (.ref_clk, .rst, .addr, .wrData, .wrEn, .rdEn, .rdData,
  .eventPin0, .eventPin1, .rtcTick, .rtcAllowed, .useRtc0, .useRtc1, .irqRequest, .wakeUp, .toggleOut);
